// ==== rtl/boundary_pkg.sv ====
package boundary_pkg;
  localparam int DATA_W = 32;
  localparam int SIZE_W = 12;
  localparam logic [SIZE_W-1:0] SIZE_RESET = 12'h020;
  localparam logic [SIZE_W-1:0] SIZE_MIN = 12'h001;
  localparam logic [SIZE_W-1:0] COUNT_ZERO = 12'h000;
  localparam logic [SIZE_W-1:0] COUNT_ONE = 12'h001;
  localparam int BUF_DEPTH = 2;
  localparam logic [1:0] BUF_EMPTY = 2'h0;
  localparam logic [1:0] BUF_ONE = 2'h1;
  localparam logic [1:0] BUF_FULL = 2'h2;
  localparam logic BLOCKING_RESET = 1'b0;

  // Source end sequencer
  typedef enum logic [1:0] {
    SRC_IDLE = 2'b00,
    SRC_CTRL = 2'b01,
    SRC_DATA = 2'b11
  } src_state_t;
endpackage : boundary_pkg

// ==== rtl/stream_link_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface stream_link_if;
  import boundary_pkg::*;
  // Data channel
  logic [DATA_W-1:0] data_tdata;
  logic data_tvalid;
  logic data_tready;
  logic data_tlast;
  // Control channel
  logic [SIZE_W-1:0] ctrl_tdata;
  logic ctrl_tvalid;
  logic ctrl_tready;

  modport core
  (
    input data_tdata,
    input data_tvalid,
    output data_tready,
    input data_tlast,
    input ctrl_tdata,
    input ctrl_tvalid,
    output ctrl_tready
  );
  modport source
  (
    output data_tdata,
    output data_tvalid,
    input data_tready,
    output data_tlast,
    output ctrl_tdata,
    output ctrl_tvalid,
    input ctrl_tready
  );
endinterface : stream_link_if
`default_nettype wire

// ==== rtl/stream_packet_boundary_checker.sv ====
// Overview of operation
// - Pulse missing event at boundary without last
// - Pulse unexpected event on early last
// - Two separate event outputs, one per type
// - Events may lag the causing beat
// - Grouped packet yields one missing per boundary before its final one
// - Both events fire while streaming continues
// - Blocking channel holds work until control arrives
// - Blocking: start needs control plus data
// - Non-blocking: start reuses last control
// - Blocking: one control, one output packet
// - Source sends new control before data
// - Blocking: source sends control every packet
// - Non-blocking: control only on change
// - Ready high while buffer has space
// - Source packet length equals transform size
// - Control carries transform size for framing
// - Events are not sticky
// - Framing counts beats, ignores last
// - Events never stall the stream
`timescale 1ns/10ps
`default_nettype none
module stream_packet_boundary_checker
  import boundary_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Upstream channels
  stream_link_if.core link,
  // Mode
  input wire logic blocking,
  // Output stream
  output logic [DATA_W-1:0] out_tdata,
  output logic out_tlast,
  output logic out_tvalid,
  input wire logic out_tready,
  // Events
  output logic missing_last,
  output logic unexpected_last,
  output logic packet_start
);
  typedef struct packed {
    logic [DATA_W-1:0] buf_data0;
    logic [DATA_W-1:0] buf_data1;
    logic buf_last0;
    logic buf_last1;
    logic buf_rd;
    logic [1:0] buf_cnt;
    logic [SIZE_W-1:0] pend_size;
    logic pend_valid;
    logic [SIZE_W-1:0] cur_size;
    logic [SIZE_W-1:0] beat_cnt;
    logic [DATA_W-1:0] odata;
    logic olast;
    logic ovalid;
    logic miss;
    logic unexp;
    logic start;
  } core_state_t;

  core_state_t s_q, s_d;

  function automatic logic [SIZE_W-1:0] clamp_size(
    input logic [SIZE_W-1:0] sz
  );
    clamp_size = (sz < SIZE_MIN) ? SIZE_MIN : sz;
  endfunction : clamp_size

  logic take_in;
  logic buf_has;
  logic can_issue;
  logic at_boundary;
  logic issue;
  logic buf_last_head;
  logic [DATA_W-1:0] buf_data_head;

  // Two-entry buffer; ready depends only on free space
  assign link.data_tready = (s_q.buf_cnt != BUF_FULL);
  assign take_in = link.data_tvalid && link.data_tready;
  assign buf_has = (s_q.buf_cnt != BUF_EMPTY);
  assign buf_data_head = s_q.buf_rd ? s_q.buf_data1 : s_q.buf_data0;
  assign buf_last_head = s_q.buf_rd ? s_q.buf_last1 : s_q.buf_last0;
  // Control is held one deep so a stall never drops it
  assign link.ctrl_tready = !s_q.pend_valid;
  assign at_boundary = (s_q.beat_cnt == COUNT_ZERO);
  // Blocking gates the packet start on a control word
  // Each blocking packet needs a fresh control word, none carried over
  assign can_issue = !at_boundary || !blocking
    || s_q.pend_valid;
  assign issue = buf_has && can_issue && (!s_q.ovalid || out_tready);

  always_comb
  begin
    logic [SIZE_W-1:0] size_now;
    logic end_beat;
    size_now = s_q.cur_size;
    end_beat = 1'b0;
    s_d = s_q;
    s_d.miss = 1'b0;
    s_d.unexp = 1'b0;
    s_d.start = 1'b0;
    if (s_q.ovalid && out_tready)
    begin
      s_d.ovalid = 1'b0;
    end
    if (link.ctrl_tvalid && link.ctrl_tready)
    begin
      s_d.pend_size = clamp_size(link.ctrl_tdata);
      s_d.pend_valid = 1'b1;
    end
    if (issue)
    begin
      if (at_boundary && s_q.pend_valid)
      begin
        size_now = s_q.pend_size;
        s_d.pend_valid = 1'b0;
      end
      if (at_boundary)
      begin
        s_d.cur_size = size_now;
        s_d.start = 1'b1;
      end
      end_beat = (s_q.beat_cnt == size_now - COUNT_ONE);
      // Framing ignores last; events only report
      s_d.miss = end_beat && !buf_last_head;
      s_d.unexp = !end_beat && buf_last_head;
      s_d.beat_cnt = end_beat ? COUNT_ZERO
        : s_q.beat_cnt + COUNT_ONE;
      s_d.odata = buf_data_head;
      s_d.olast = end_beat;
      s_d.ovalid = 1'b1;
      s_d.buf_rd = !s_q.buf_rd;
    end
    if (take_in)
    begin
      if (s_q.buf_rd ^ s_q.buf_cnt[0])
      begin
        s_d.buf_data1 = link.data_tdata;
        s_d.buf_last1 = link.data_tlast;
      end
      else
      begin
        s_d.buf_data0 = link.data_tdata;
        s_d.buf_last0 = link.data_tlast;
      end
    end
    case ({take_in, issue})
      2'b10: s_d.buf_cnt = s_q.buf_cnt + BUF_ONE;
      2'b01: s_d.buf_cnt = s_q.buf_cnt - BUF_ONE;
      default: s_d.buf_cnt = s_q.buf_cnt;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.cur_size <= SIZE_RESET;
      s_q.pend_size <= SIZE_RESET;
      s_q.beat_cnt <= COUNT_ZERO;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign out_tdata = s_q.odata;
  assign out_tlast = s_q.olast;
  assign out_tvalid = s_q.ovalid;
  // Events registered one cycle after the beat is framed
  assign missing_last = s_q.miss;
  assign unexpected_last = s_q.unexp;
  assign packet_start = s_q.start;
endmodule : stream_packet_boundary_checker
`default_nettype wire

// ==== rtl/stream_packet_source.sv ====
`timescale 1ns/10ps
`default_nettype none
module stream_packet_source
  import boundary_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link to core
  stream_link_if.source link,
  // Job request
  input wire logic job_valid,
  output logic job_ready,
  input wire logic job_send_ctrl,
  input wire logic [SIZE_W-1:0] job_size,
  input wire logic [SIZE_W-1:0] job_len,
  // Data feed
  input wire logic [DATA_W-1:0] feed_data,
  input wire logic feed_valid,
  output logic feed_ready,
  // Status
  output logic busy
);
  typedef struct packed {
    src_state_t st;
    logic [SIZE_W-1:0] csize;
    logic [SIZE_W-1:0] left;
    logic [DATA_W-1:0] tdata;
    logic tlast;
    logic tvalid;
  } src_reg_t;

  src_reg_t s_q, s_d;
  logic load;

  assign job_ready = (s_q.st == SRC_IDLE);
  // Sample feed only when the output slot is free
  assign load = (s_q.st == SRC_DATA) && feed_valid
    && (!s_q.tvalid || link.data_tready) && (s_q.left != COUNT_ZERO);
  assign feed_ready = load;

  always_comb
  begin
    s_d = s_q;
    if (s_q.tvalid && link.data_tready)
    begin
      s_d.tvalid = 1'b0;
    end
    case (s_q.st)
      SRC_IDLE:
      begin
        if (job_valid)
        begin
          s_d.csize = job_size;
          s_d.left = job_len;
          // Control is sent ahead of its data
          s_d.st = job_send_ctrl ? SRC_CTRL : SRC_DATA;
        end
      end
      SRC_CTRL:
      begin
        if (link.ctrl_tready)
        begin
          s_d.st = SRC_DATA;
        end
      end
      SRC_DATA:
      begin
        if (load)
        begin
          s_d.tdata = feed_data;
          s_d.tlast = (s_q.left == COUNT_ONE);
          s_d.tvalid = 1'b1;
          s_d.left = s_q.left - COUNT_ONE;
        end
        if (s_q.left == COUNT_ZERO && !s_d.tvalid)
        begin
          s_d.st = SRC_IDLE;
        end
      end
      default: s_d.st = SRC_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign link.ctrl_tdata = s_q.csize;
  assign link.ctrl_tvalid = (s_q.st == SRC_CTRL);
  assign link.data_tdata = s_q.tdata;
  assign link.data_tlast = s_q.tlast;
  assign link.data_tvalid = s_q.tvalid;
  assign busy = (s_q.st != SRC_IDLE);
endmodule : stream_packet_source
`default_nettype wire

// ==== testbench/boundary_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module boundary_sva
  import boundary_pkg::*;
(
  // Clock, reset and link
  input wire logic clk,
  input wire logic rst,
  input wire logic [DATA_W-1:0] data_tdata,
  input wire logic data_tvalid,
  input wire logic data_tready,
  // Core outputs
  input wire logic out_tvalid,
  input wire logic out_tready,
  input wire logic out_tlast,
  input wire logic missing_last,
  input wire logic unexpected_last,
  input wire logic packet_start
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // A second pulse is legal only for a fresh beat after a taken one
  miss_pulse_a: assert property
    (missing_last |=> !missing_last || $past(out_tready))
    else $error("missing event held");
  unexp_pulse_a: assert property
    (unexpected_last |=> !unexpected_last || $past(out_tready))
    else $error("unexpected event held");
  miss_at_end_a: assert property
    (missing_last |-> out_tvalid && out_tlast)
    else $error("missing event off boundary");
  unexp_early_a: assert property
    (unexpected_last |-> out_tvalid && !out_tlast)
    else $error("unexpected event on boundary");
  one_kind_a: assert property (!(missing_last && unexpected_last))
    else $error("both events on one beat");
  out_hold_a: assert property
    (out_tvalid && !out_tready |=> out_tvalid && $stable(out_tlast))
    else $error("output beat dropped");
  ready_free_a: assert property
    (data_tready && !data_tvalid |=> data_tready)
    else $error("ready fell with buffer space");
  src_hold_a: assert property
    (data_tvalid && !data_tready |=> data_tvalid && $stable(data_tdata))
    else $error("source beat changed");
  start_pulse_a: assert property (packet_start |-> out_tvalid)
    else $error("start without beat");
  cover property (missing_last);
  cover property (unexpected_last);
  cover property (!data_tready);
  cover property (packet_start && out_tvalid);
endmodule : boundary_sva
`default_nettype wire

// ==== testbench/tb_stream_packet_boundary_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_stream_packet_boundary_checker;
  import boundary_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic blocking = 1'b0;
  logic out_tready = 1'b1;
  logic job_valid = 1'b0;
  logic job_send_ctrl = 1'b0;
  logic [SIZE_W-1:0] job_size = 12'h000;
  logic [SIZE_W-1:0] job_len = 12'h000;
  logic [DATA_W-1:0] feed_data = 32'h00000000;
  logic [DATA_W-1:0] exp_d = 32'h00000000;
  logic feed_valid = 1'b1;
  logic fed = 1'b0;
  logic [DATA_W-1:0] out_tdata;
  logic out_tlast, out_tvalid, missing_last, unexpected_last;
  logic packet_start, job_ready, feed_ready, busy;
  int n_fail = 0;
  int comparisons = 0;
  int n_miss, n_unexp, n_pkts, n_full, n_start;
  stream_link_if lnk();
  stream_packet_source stream_packet_source_i (.clk(clk), .rst(rst),
    .link(lnk), .job_valid(job_valid), .job_ready(job_ready),
    .job_send_ctrl(job_send_ctrl), .job_size(job_size),
    .job_len(job_len), .feed_data(feed_data), .feed_valid(feed_valid),
    .feed_ready(feed_ready), .busy(busy));
  stream_packet_boundary_checker stream_packet_boundary_checker_i (
    .clk(clk), .rst(rst), .link(lnk), .blocking(blocking),
    .out_tdata(out_tdata), .out_tlast(out_tlast), .out_tvalid(out_tvalid),
    .out_tready(out_tready), .missing_last(missing_last),
    .unexpected_last(unexpected_last), .packet_start(packet_start));
  boundary_sva boundary_sva_i (.clk(clk), .rst(rst),
    .data_tdata(lnk.data_tdata), .data_tvalid(lnk.data_tvalid),
    .data_tready(lnk.data_tready), .out_tvalid(out_tvalid),
    .out_tready(out_tready), .out_tlast(out_tlast),
    .missing_last(missing_last), .unexpected_last(unexpected_last),
    .packet_start(packet_start));
  initial forever #5 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  // Incrementing feed makes lost or repeated words visible
  always @(posedge clk)
  begin
    if (!rst)
    begin
      fed <= feed_valid && feed_ready;
      if (missing_last === 1'b1)
        n_miss++;
      if (packet_start === 1'b1)
        n_start++;
      if (unexpected_last === 1'b1)
        n_unexp++;
      if (lnk.data_tready === 1'b0)
        n_full++;
      if (out_tvalid === 1'b1 && out_tready)
      begin
        check(out_tdata, exp_d);
        exp_d = exp_d + 32'h1;
        if (out_tlast === 1'b1)
          n_pkts++;
      end
    end
  end

  // Feed word moves on off the sampling edge
  always @(negedge clk)
  begin
    if (fed)
      feed_data = feed_data + 32'h1;
  end

  task automatic settle(input int k);
    int i;
    for (i = 0; i < 400 && busy !== 1'b0; i++)
      @(negedge clk);
    if (i == 400)
    begin
      n_fail++;
      give_verdict();
    end
    repeat (k) @(negedge clk);
  endtask : settle

  task automatic job(input logic c, input int s, input int l);
    settle(1);
    check(job_ready, 1'b1);
    job_send_ctrl = c;
    job_size = s[11:0];
    job_len = l[11:0];
    job_valid = 1'b1;
    @(negedge clk);
    job_valid = 1'b0;
  endtask : job

  task automatic clr;
    n_miss = 0;
    n_unexp = 0;
    n_pkts = 0;
    n_full = 0;
    n_start = 0;
  endtask : clr

  task automatic expect_ev(input int m, input int u, input int p);
    settle(6);
    check(n_miss, m);
    check(n_unexp, u);
    check(n_pkts, p);
    check(n_start, p);
    clr();
  endtask : expect_ev

  initial
  begin
    clr();
    repeat (12) @(negedge clk);
    rst = 1'b0;
    job(1'b1, 4, 4);
    expect_ev(0, 0, 1);
    job(1'b0, 0, 12);
    expect_ev(2, 0, 3);
    job(1'b0, 0, 3);
    job(1'b0, 0, 3);
    job(1'b0, 0, 2);
    expect_ev(1, 2, 2);
    out_tready = 1'b0;
    job(1'b0, 0, 8);
    repeat (20) @(negedge clk);
    check(n_full != 0, 1);
    out_tready = 1'b1;
    expect_ev(1, 0, 2);
    job(1'b0, 0, 2);
    job(1'b1, 2, 2);
    job(1'b0, 0, 2);
    expect_ev(0, 1, 2);
    blocking = 1'b1;
    job(1'b1, 2, 0);
    job(1'b0, 0, 4);
    repeat (30) @(negedge clk);
    check(n_pkts, 1);
    blocking = 1'b0;
    expect_ev(1, 0, 2);
    give_verdict();
  end
endmodule : tb_stream_packet_boundary_checker
`default_nettype wire
